// *** pd_pkg.sv ***
// package for the power-down mode controller: register map, fields, timing
// assumes a single 100 MHz clock domain
package pd_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] EDGE_CFG_ADDR = 16'hF1C0;
  localparam logic [15:0] SYSCFG_ADDR = 16'hFF12;
  localparam logic [15:0] EDGE_CFG_RESET = 16'h0000;
  localparam logic [15:0] SYSCFG_RESET = 16'h0000;
  localparam int MODE_SEL_BIT = 5;
  localparam int NUM_PINS = 8;

  // ==========================================================
  // edge selection field codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // ==========================================================
  // timing: least wake pulse on a pin
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_PULSE_NS = 40;
  localparam int WAKE_CYCLES = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DOWN,
    ST_WAKE,
    ST_RESUME
  } pd_state_t;

endpackage

// *** pd_pin_sync.sv ***
// two-flop synchroniser for the external pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module pd_pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic [pd_pkg::NUM_PINS-1:0] pin_async,
  input wire logic nmi_n_async,
  input wire logic wake_delay_low_async,
  output logic [pd_pkg::NUM_PINS-1:0] pin_sync,
  output logic nmi_n_sync,
  output logic wake_delay_low_sync
);

  logic [pd_pkg::NUM_PINS+1:0] meta_q;
  logic [pd_pkg::NUM_PINS+1:0] sync_q;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      // nmi idles high: reset it high so no false low follows reset
      meta_q <= {1'b0, 1'b1, {pd_pkg::NUM_PINS{1'b0}}};
      sync_q <= {1'b0, 1'b1, {pd_pkg::NUM_PINS{1'b0}}};
    end else begin
      meta_q <= {wake_delay_low_async, nmi_n_async, pin_async};
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q[pd_pkg::NUM_PINS-1:0];
  assign nmi_n_sync = sync_q[pd_pkg::NUM_PINS];
  assign wake_delay_low_sync = sync_q[pd_pkg::NUM_PINS+1];

endmodule

// *** pd_ctrl.sv ***
// power-down mode controller: entry check, clock freeze, wake sequence
// assumes cpu pulses powerdown_instruction and end_init_instruction on clk
//
// Overview of operation
// RULE_01 - configuration bit zero selects protected power-down
// RULE_02 - protected entry only while non-maskable interrupt pin is low
// RULE_03 - failed entry check makes the instruction a no-op
// RULE_04 - memory and registers are untouched during power-down
// RULE_05 - protected mode wakes only by hardware reset
// RULE_06 - configuration bit one selects interruptible power-down
// RULE_07 - interruptible entry needs every enabled pin at its inactive level
// RULE_08 - field 00 disables the pin for entry and wake
// RULE_09 - field 01: rising edge, enter while low, wake when high
// RULE_10 - field 10: falling edge, enter while high, wake when low
// RULE_11 - field 11: any edge, never blocks entry, wakes on change
// RULE_12 - entering freezes clocks and stops oscillator and pll
// RULE_13 - interruptible mode wakes on reset or a qualifying pin
// RULE_14 - external party holds reset until oscillator and pll settle
// RULE_15 - wake logic treats pins as levels, not sampled inputs
// RULE_16 - wake works even if the pin interrupt enable is clear
// RULE_17 - external source holds wake level at least 40 ns
// RULE_18 - wake restarts oscillator, pulls delay pin, gates clocks until low
// RULE_19 - enabled interrupt runs its service routine after wake
// RULE_20 - disabled interrupt leaves its request flag set for software
// RULE_21 - one instruction after power-down runs before the service call
// RULE_22 - configuration select is read-write bit 5 of system config
// RULE_23 - system config writes blocked after end of initialisation
// RULE_24 - entry check uses pin levels in the instruction cycle
`timescale 1ns/1ps
module pd_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic powerdown_instruction,
  input wire logic end_init_instruction,
  input wire logic nmi_n_pin,
  input wire logic [pd_pkg::NUM_PINS-1:0] fast_ext_irq_pin,
  input wire logic [pd_pkg::NUM_PINS-1:0] irq_enable_bit,
  input wire logic [pd_pkg::NUM_PINS-1:0] irq_flag_clear,
  input wire logic wake_delay_low,
  output logic clocks_gated,
  output logic osc_pll_stop,
  output logic wake_delay_pulldown,
  output logic powerdown_active,
  output logic pd_ignored,
  output logic resume_pulse,
  output logic [pd_pkg::NUM_PINS-1:0] irq_request_flag,
  output logic [pd_pkg::NUM_PINS-1:0] isr_request
);

  pd_pkg::pd_state_t state_q, state_d;
  logic [15:0] edge_cfg_q;
  logic [15:0] sys_cfg_q;
  logic init_done_q;
  logic [pd_pkg::NUM_PINS-1:0] pin_s, entry_lvl_q, wake_src_q, ien_q;
  logic nmi_n_s, delay_low_s;
  logic [2:0] wake_cnt_q;
  logic [15:0] rdata_q;
  logic [pd_pkg::NUM_PINS-1:0] flag_q, isr_q;
  logic ign_q, resume_q;

  // ==========================================================
  // pin synchronisers
  pd_pin_sync pd_pin_sync_inst (
    .clk(clk),
    .srst(srst),
    .pin_async(fast_ext_irq_pin),
    .nmi_n_async(nmi_n_pin),
    .wake_delay_low_async(wake_delay_low),
    .pin_sync(pin_s),
    .nmi_n_sync(nmi_n_s),
    .wake_delay_low_sync(delay_low_s)
  );

  // per-pin field extraction
  function automatic logic [1:0] field_of(input logic [15:0] cfg, input int idx);
    field_of = cfg[2*idx +: 2];
  endfunction

  // ==========================================================
  // entry and wake qualification per pin
  logic [pd_pkg::NUM_PINS-1:0] pin_blocks, pin_wakes;
  always_comb begin
    for (int i = 0; i < pd_pkg::NUM_PINS; i++) begin
      // RULE_08 RULE_09 RULE_10 RULE_11 field decode
      case (field_of(edge_cfg_q, i))
        pd_pkg::EDGE_RISE: begin
          pin_blocks[i] = pin_s[i];
          pin_wakes[i] = pin_s[i];
        end
        pd_pkg::EDGE_FALL: begin
          pin_blocks[i] = !pin_s[i];
          pin_wakes[i] = !pin_s[i];
        end
        pd_pkg::EDGE_ANY: begin
          pin_blocks[i] = 1'b0;
          pin_wakes[i] = pin_s[i] != entry_lvl_q[i];
        end
        default: begin
          pin_blocks[i] = 1'b0;
          pin_wakes[i] = 1'b0;
        end
      endcase
    end
  end

  // RULE_01 RULE_06 mode select from bit 5
  wire mode_intr = sys_cfg_q[pd_pkg::MODE_SEL_BIT];
  // RULE_02 RULE_07 RULE_24 entry check in the instruction cycle
  wire entry_ok = mode_intr ? (pin_blocks == '0) : !nmi_n_s;
  wire pd_req = (state_q == pd_pkg::ST_RUN) && powerdown_instruction;
  // RULE_15 RULE_16 level-held wake qualified by the pulse counter
  wire any_wake_lvl = |pin_wakes;
  wire wake_valid = any_wake_lvl && (wake_cnt_q >= 3'(pd_pkg::WAKE_CYCLES - 1));
  wire sys_wr = reg_wr && (reg_addr == pd_pkg::SYSCFG_ADDR) && !init_done_q;
  wire edge_wr = reg_wr && (reg_addr == pd_pkg::EDGE_CFG_ADDR);
  wire [15:0] rd_mux = (reg_addr == pd_pkg::EDGE_CFG_ADDR) ? edge_cfg_q :
                       (reg_addr == pd_pkg::SYSCFG_ADDR) ? sys_cfg_q : 16'h0000;

  // ==========================================================
  // state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      pd_pkg::ST_RUN: begin
        // RULE_03 failed check stays in run
        if (pd_req && entry_ok) begin
          state_d = pd_pkg::ST_DOWN;
        end
      end
      pd_pkg::ST_DOWN: begin
        // RULE_05 RULE_13 only pins wake, and only in interruptible mode
        if (mode_intr && wake_valid) begin
          state_d = pd_pkg::ST_WAKE;
        end
      end
      pd_pkg::ST_WAKE: begin
        // RULE_18 clocks stay gated until delay pin is low
        if (delay_low_s) begin
          state_d = pd_pkg::ST_RESUME;
        end
      end
      pd_pkg::ST_RESUME: begin
        state_d = pd_pkg::ST_RUN;
      end
      default: begin
        state_d = pd_pkg::ST_RUN;
      end
    endcase
  end

  // state and status outputs; reset is the hardware wake
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= pd_pkg::ST_RUN;
      clocks_gated <= 1'b0;
      osc_pll_stop <= 1'b0;
      wake_delay_pulldown <= 1'b0;
      powerdown_active <= 1'b0;
    end else begin
      state_q <= state_d;
      // RULE_12 freeze clocks and stop oscillator
      clocks_gated <= (state_d == pd_pkg::ST_DOWN) || (state_d == pd_pkg::ST_WAKE);
      osc_pll_stop <= state_d == pd_pkg::ST_DOWN;
      // RULE_18 weak pull-down during wake delay
      wake_delay_pulldown <= state_d == pd_pkg::ST_WAKE;
      powerdown_active <= state_d == pd_pkg::ST_DOWN;
    end
  end

  // ==========================================================
  // wake pulse width counter
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_cnt_q <= 3'h0;
    end else if (state_q == pd_pkg::ST_DOWN && any_wake_lvl) begin
      wake_cnt_q <= (wake_cnt_q == 3'h7) ? wake_cnt_q : wake_cnt_q + 3'h1;
    end else begin
      wake_cnt_q <= 3'h0;
    end
  end

  // entry snapshot of levels and enables, wake source capture
  always_ff @(posedge clk) begin
    if (srst) begin
      entry_lvl_q <= '0;
      ien_q <= '0;
      wake_src_q <= '0;
    end else if (pd_req && entry_ok) begin
      entry_lvl_q <= pin_s;
      ien_q <= irq_enable_bit;
      wake_src_q <= '0;
    end else if (state_q == pd_pkg::ST_DOWN && state_d == pd_pkg::ST_WAKE) begin
      wake_src_q <= pin_wakes;
    end
  end

  // ==========================================================
  // registers; RULE_04 entry and pin wake leave them unchanged, the reset wake reloads them
  always_ff @(posedge clk) begin
    if (srst) begin
      edge_cfg_q <= pd_pkg::EDGE_CFG_RESET;
      sys_cfg_q <= pd_pkg::SYSCFG_RESET;
      init_done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      if (edge_wr) begin
        edge_cfg_q <= reg_wdata;
      end
      // RULE_22 RULE_23 write lock after end of init
      if (sys_wr) begin
        sys_cfg_q <= reg_wdata;
      end
      if (end_init_instruction) begin
        init_done_q <= 1'b1;
      end
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // resume: flags and service requests
  wire resume_now = state_q == pd_pkg::ST_RESUME;
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= '0;
      isr_q <= '0;
      ign_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      // RULE_20 flag set on wake wins over clear
      flag_q <= (flag_q & ~irq_flag_clear) | (resume_now ? wake_src_q : '0);
      // RULE_19 RULE_21 service request after the resume cycle
      isr_q <= resume_now ? (wake_src_q & ien_q) : '0;
      ign_q <= pd_req && !entry_ok;
      resume_q <= resume_now;
    end
  end
  assign irq_request_flag = flag_q;
  assign isr_request = isr_q;
  assign pd_ignored = ign_q;
  assign resume_pulse = resume_q;

  // ==========================================================
  // assertions
  // RULE_05 protected hold
  prot_hold_a: assert property (@(posedge clk) disable iff (srst)
    state_q == pd_pkg::ST_DOWN && !mode_intr |=> state_q == pd_pkg::ST_DOWN)
    else $error("protected power-down left without reset");
  // RULE_03 ignored instruction
  ignore_run_a: assert property (@(posedge clk) disable iff (srst)
    pd_req && !entry_ok |=> state_q == pd_pkg::ST_RUN ##0 pd_ignored)
    else $error("failed entry check not ignored");
  // RULE_02 RULE_07 entry
  entry_ok_a: assert property (@(posedge clk) disable iff (srst)
    pd_req && entry_ok |=> powerdown_active && osc_pll_stop)
    else $error("entry check passed but no power-down");
  // RULE_12 clocks frozen
  clk_freeze_a: assert property (@(posedge clk) disable iff (srst)
    powerdown_active |-> clocks_gated && osc_pll_stop)
    else $error("clocks running in power-down");
  // RULE_18 gating held
  gate_hold_a: assert property (@(posedge clk) disable iff (srst)
    state_q == pd_pkg::ST_WAKE && !delay_low_s |=> clocks_gated && wake_delay_pulldown)
    else $error("clocks released before delay pin low");
  // RULE_13 RULE_17 wake time
  wake_go_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == pd_pkg::ST_DOWN && mode_intr && any_wake_lvl) [*4] |-> ##1
    state_q == pd_pkg::ST_WAKE)
    else $error("held wake level did not wake");
  // RULE_17 short pulse
  short_pulse_a: assert property (@(posedge clk) disable iff (srst)
    $rose(state_q == pd_pkg::ST_WAKE) |-> $past(any_wake_lvl, 3))
    else $error("wake on pulse shorter than minimum");
  // RULE_19 RULE_20 resume outputs
  resume_out_a: assert property (@(posedge clk) disable iff (srst)
    resume_now |=> resume_pulse && ((irq_request_flag & wake_src_q) == wake_src_q))
    else $error("resume did not set request flags");
  // RULE_23 lock
  sys_lock_a: assert property (@(posedge clk) disable iff (srst)
    init_done_q |=> $stable(sys_cfg_q))
    else $error("system config changed after end of init");
  // RULE_18 oscillator restarted
  osc_restart_a: assert property (@(posedge clk) disable iff (srst)
    state_q == pd_pkg::ST_WAKE |-> !osc_pll_stop && wake_delay_pulldown)
    else $error("oscillator still stopped during wake delay");
  // RULE_20 flags held
  flag_hold_a: assert property (@(posedge clk) disable iff (srst)
    irq_request_flag != '0 && irq_flag_clear == '0 |=>
    (irq_request_flag & $past(irq_request_flag)) == $past(irq_request_flag))
    else $error("request flag lost without a clear");

  cov_prot_c: cover property (@(posedge clk) disable iff (srst)
    pd_req && entry_ok && !mode_intr);
  cov_intr_wake_c: cover property (@(posedge clk) disable iff (srst)
    state_q == pd_pkg::ST_WAKE ##[1:50] resume_now);
  cov_ignore_c: cover property (@(posedge clk) disable iff (srst) pd_ignored);
  cov_isr_c: cover property (@(posedge clk) disable iff (srst) |isr_request);

endmodule

// *** pd_far_side.sv ***
// far-side model: power-fail detector, wake pulse sources, rc on the delay pin
// assumes the bench drives its controls on rising edges of clk
`timescale 1ns/1ps
module pd_far_side #(
  parameter int RC_CYCLES = 20,
  parameter int HOLD_CYCLES = 6
) (
  input wire logic clk,
  input wire logic power_fail,
  input wire logic [7:0] idle_level,
  input wire logic wake_req,
  input wire logic [2:0] wake_pin,
  input wire logic wake_delay_pulldown,
  output logic nmi_n_pin,
  output logic [7:0] fast_ext_irq_pin,
  output logic wake_delay_low
);
  logic [7:0] mask_q = 8'h00;
  int hold_q = 0;
  int rc_q = 0;
  // ==========================================================
  // pin levels
  // detector pulls the nmi line low on power failure
  assign nmi_n_pin = ~power_fail;
  assign fast_ext_irq_pin = idle_level ^ mask_q;
  // capacitor below threshold once discharged long enough
  assign wake_delay_low = (rc_q >= RC_CYCLES);
  // ==========================================================
  // pulse length and discharge timing
  always @(posedge clk) begin
    if (wake_req) begin
      mask_q <= 8'h01 << wake_pin;
      hold_q <= HOLD_CYCLES;
    end else if (hold_q > 1) begin
      hold_q <= hold_q - 1;
    end else begin
      hold_q <= 0;
      mask_q <= 8'h00;
    end
    rc_q <= wake_delay_pulldown ? rc_q + 1 : 0;
  end
endmodule

// *** power_down_mode_control_tb.sv ***
// bench for the power-down controller: registers, protected and pin wake
// assumes pd_ctrl and the far-side model on one 100 MHz clock
`timescale 1ns/1ps
module power_down_mode_control_tb;
  localparam logic [15:0] EC = pd_pkg::EDGE_CFG_ADDR;
  localparam logic [15:0] SC = pd_pkg::SYSCFG_ADDR;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic powerdown_instruction = 1'b0;
  logic end_init_instruction = 1'b0;
  logic [7:0] irq_enable_bit = 8'h00;
  logic [7:0] irq_flag_clear = 8'h00;
  logic nmi_n_pin, wake_delay_low, clocks_gated, osc_pll_stop, wake_delay_pulldown;
  logic powerdown_active, pd_ignored, resume_pulse;
  logic [7:0] fast_ext_irq_pin, irq_request_flag, isr_request;
  logic power_fail = 1'b0;
  logic [7:0] idle_level = 8'h00;
  logic wake_req = 1'b0;
  logic [2:0] wake_pin = 3'h0;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'hDE77;

  always #5 clk = ~clk;

  pd_ctrl pd_ctrl_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .powerdown_instruction(powerdown_instruction), .end_init_instruction(end_init_instruction),
    .nmi_n_pin(nmi_n_pin), .fast_ext_irq_pin(fast_ext_irq_pin), .irq_enable_bit(irq_enable_bit),
    .irq_flag_clear(irq_flag_clear), .wake_delay_low(wake_delay_low),
    .clocks_gated(clocks_gated), .osc_pll_stop(osc_pll_stop),
    .wake_delay_pulldown(wake_delay_pulldown), .powerdown_active(powerdown_active),
    .pd_ignored(pd_ignored), .resume_pulse(resume_pulse),
    .irq_request_flag(irq_request_flag), .isr_request(isr_request));

  pd_far_side pd_far_side_inst (.clk(clk), .power_fail(power_fail), .idle_level(idle_level),
    .wake_req(wake_req), .wake_pin(wake_pin), .wake_delay_pulldown(wake_delay_pulldown),
    .nmi_n_pin(nmi_n_pin), .fast_ext_irq_pin(fast_ext_irq_pin), .wake_delay_low(wake_delay_low));

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // level of a pin that blocks entry for its field code
  function automatic logic active_lvl(input logic [1:0] code);
    return (code == pd_pkg::EDGE_RISE);
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // set pin levels, then let the synchroniser settle
  task automatic pins(input logic pf, input logic [7:0] lvl);
    @(posedge clk);
    power_fail <= pf;
    idle_level <= lvl;
    repeat (3) @(posedge clk);
  endtask

  task automatic pdi();
    @(posedge clk);
    powerdown_instruction <= 1'b1;
    @(posedge clk);
    powerdown_instruction <= 1'b0;
    #1;
  endtask

  task automatic wake(input int idx);
    @(posedge clk);
    wake_pin <= idx[2:0];
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
  endtask

  // ==========================================================
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    int i;
    logic [1:0] code;
    logic [7:0] lvl, en, m;
    logic [15:0] cfg;
    logic saw_pd;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(EC, pd_pkg::EDGE_CFG_RESET);
    rd(SC, pd_pkg::SYSCFG_RESET);
    rd(16'h1234, 16'h0000);
    // protected mode, pin 0 armed for rising wake
    wr(EC, 16'h0001);
    pins(1'b0, 8'h00);
    pdi();
    chk(pd_ignored, 16'h0001);
    chk(powerdown_active, 16'h0000);
    pins(1'b1, 8'h00);
    pdi();
    chk(powerdown_active, 16'h0001);
    chk(osc_pll_stop & clocks_gated, 16'h0001);
    wake(0);
    repeat (40) @(posedge clk);
    #1;
    chk(powerdown_active, 16'h0001);
    @(posedge clk);
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(powerdown_active | clocks_gated, 16'h0000);
    // interruptible mode, then lock the system config
    wr(SC, 16'h0020);
    @(posedge clk);
    end_init_instruction <= 1'b1;
    @(posedge clk);
    end_init_instruction <= 1'b0;
    wr(SC, 16'h0000);
    rd(SC, 16'h0020);
    for (int k = 0; k < 9; k++) begin
      i = $random(seed) & 7;
      code = 2'(k % 3 + 1);
      lvl = 8'($random(seed));
      en = 8'($random(seed));
      m = 8'h01 << i;
      cfg = 16'(code) << (2 * i);
      if (code != pd_pkg::EDGE_ANY) begin
        lvl = active_lvl(code) ? lvl & ~m : lvl | m;
      end
      wr(EC, cfg);
      irq_enable_bit <= en;
      if (code != pd_pkg::EDGE_ANY) begin
        pins(1'b0, lvl ^ m);
        pdi();
        chk(pd_ignored, 16'h0001);
      end
      pins(1'b0, lvl);
      pdi();
      chk(powerdown_active, 16'h0001);
      wake((i + 1) % 8);
      repeat (15) @(posedge clk);
      #1;
      chk(powerdown_active, 16'h0001);
      wake(i);
      saw_pd = 1'b0;
      for (int t = 0; t < 100; t++) begin
        @(posedge clk);
        #1;
        if (wake_delay_pulldown === 1'b1) begin
          saw_pd = 1'b1;
          chk({osc_pll_stop, clocks_gated}, 16'h0001);
        end
        if (resume_pulse === 1'b1) begin
          break;
        end
      end
      chk(resume_pulse, 16'h0001);
      chk(saw_pd, 16'h0001);
      chk(irq_request_flag, m);
      chk(isr_request, en & m);
      rd(EC, cfg);
      chk(irq_request_flag, m);
      @(posedge clk);
      irq_flag_clear <= m;
      @(posedge clk);
      irq_flag_clear <= 8'h00;
      #1;
      chk(irq_request_flag, 16'h0000);
    end
    summarize();
  end
endmodule
